/* File: logic/psac_host.sv */
// host controller that drives the pseudo-static ram pins with safe timing
module psac_host #(
	parameter int WAKE_CYC = psac_pkg::WAKE_CYC_DEF,
	parameter int PU_LOW_CYC = psac_pkg::PU_LOW_CYC_DEF
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic req_valid,
	input psac_pkg::psac_req_type req,
	output logic req_ready,
	output logic [psac_pkg::DATA_W-1:0] rdata,
	output logic rdata_valid,
	output logic ready_for_use,
	output psac_pkg::psac_pins_type pins,
	input wire logic [psac_pkg::DATA_W-1:0] dq_in
);
	import psac_pkg::*;

	typedef enum logic [4:0] {
		ST_PU_LOW,
		ST_WAKE,
		ST_IDLE,
		ST_RD_ADDR,
		ST_RD_WAIT,
		ST_PG_WAIT,
		ST_RD_END,
		ST_WR_SETUP,
		ST_WR_PULSE,
		ST_WR_END,
		ST_GAP,
		ST_PD_SETUP,
		ST_PD_HOLD,
		ST_PD_OFF
	} psac_state_type;

	psac_state_type state_reg, state_next;
	psac_pins_type pins_reg, pins_next;
	psac_req_type req_reg;
	logic [DATA_W-1:0] rdata_reg, dq_s1_reg, dq_s2_reg;
	logic rvalid_reg, rvalid_next, ready_reg;
	logic [2:0] beat_reg;
	logic last_was_write_reg;
	logic tload, tdone;
	logic [CNT_W-1:0] tcount;
	logic take, pu_armed_reg;

	psac_timer u_timer (
		.core_clk(core_clk),
		.resetn(resetn),
		.load(tload),
		.count(tcount),
		.done(tdone)
	);

	assign take = req_valid && req_ready;
	assign req_ready = (state_reg == ST_IDLE) && tdone;

	// ---------------------------------------------------------------
	// data input synchroniser
	// ---------------------------------------------------------------
	// the pin bus is asynchronous; sampled twice before capture
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			dq_s1_reg <= '0;
			dq_s2_reg <= '0;
		end else begin
			dq_s1_reg <= dq_in;
			dq_s2_reg <= dq_s1_reg;
		end
	end

	// ---------------------------------------------------------------
	// next state and pin values
	// ---------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		pins_next = pins_reg;
		tload = 1'b0;
		tcount = '0;
		rvalid_next = 1'b0;
		case (state_reg)
			ST_PU_LOW: begin
				if (!pu_armed_reg) begin
					tload = 1'b1;
					tcount = CNT_W'(PU_LOW_CYC);
				end else if (tdone) begin
					pins_next.power_down_enable = 1'b1;
					tload = 1'b1;
					tcount = CNT_W'(WAKE_CYC);
					state_next = ST_WAKE;
				end
			end
			ST_WAKE: begin
				if (tdone) begin
					state_next = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (take) begin
					pins_next.output_enable_n = 1'b1;
					pins_next.write_enable_n = 1'b1;
					pins_next.addr = req.addr;
					case (req.cmd)
						PSAC_CMD_WRITE: begin
							pins_next.dq_out = req.wdata;
							pins_next.dq_oe = 1'b1;
							pins_next.low_byte_enable_n = ~req.byte_en[0];
							pins_next.high_byte_enable_n = ~req.byte_en[1];
							pins_next.primary_chip_enable_n = 1'b0;
							state_next = ST_WR_SETUP;
						end
						PSAC_CMD_SLEEP: begin
							tload = 1'b1;
							tcount = CNT_W'(PD_SETUP_CYC);
							state_next = ST_PD_SETUP;
						end
						default: begin
							pins_next.low_byte_enable_n = 1'b0;
							pins_next.high_byte_enable_n = 1'b0;
							pins_next.primary_chip_enable_n = 1'b0;
							tload = last_was_write_reg;
							tcount = CNT_W'(GAP_CYC);
							state_next = ST_RD_ADDR;
						end
					endcase
				end
			end
			ST_RD_ADDR: begin
				if (tdone) begin
					pins_next.output_enable_n = 1'b0;
					tload = 1'b1;
					// address kept a full read cycle
					tcount = CNT_W'(READ_CYC);
					state_next = ST_RD_WAIT;
				end
			end
			ST_RD_WAIT: begin
				if (tdone) begin
					rvalid_next = 1'b1;
					if (req_reg.cmd == PSAC_CMD_PAGE_READ && beat_reg != 3'(PAGE_BEATS - 1)) begin
						pins_next.addr[2:0] = pins_reg.addr[2:0] + 3'd1;
						tload = 1'b1;
						// one extra clock covers the data synchroniser
						tcount = CNT_W'(PAGE_ACC_CYC + 1);
						state_next = ST_PG_WAIT;
					end else begin
						state_next = ST_RD_END;
					end
				end
			end
			ST_PG_WAIT: begin
				if (tdone) begin
					rvalid_next = 1'b1;
					if (beat_reg == 3'(PAGE_BEATS - 1)) begin
						state_next = ST_RD_END;
					end else begin
						pins_next.addr[2:0] = pins_reg.addr[2:0] + 3'd1;
						tload = 1'b1;
						tcount = CNT_W'(PAGE_ACC_CYC + 1);
					end
				end
			end
			ST_RD_END: begin
				pins_next.primary_chip_enable_n = 1'b1;
				tload = 1'b1;
				tcount = CNT_W'(HOLD_CYC);
				state_next = ST_GAP;
			end
			ST_WR_SETUP: begin
				// last falling edge starts the pulse
				pins_next.write_enable_n = 1'b0;
				tload = 1'b1;
				tcount = CNT_W'(WPULSE_CYC);
				state_next = ST_WR_PULSE;
			end
			ST_WR_PULSE: begin
				if (tdone) begin
					pins_next.write_enable_n = 1'b1;
					tload = 1'b1;
					tcount = CNT_W'(WREC_CYC);
					state_next = ST_WR_END;
				end
			end
			ST_WR_END: begin
				// write recovery ends with chip enable
				if (tdone) begin
					// write enable stable past chip enable
					pins_next.primary_chip_enable_n = 1'b1;
					pins_next.low_byte_enable_n = 1'b1;
					pins_next.high_byte_enable_n = 1'b1;
					tload = 1'b1;
					tcount = CNT_W'(HOLD_CYC);
					state_next = ST_GAP;
				end
			end
			ST_GAP: begin
				if (tdone) begin
					pins_next.dq_oe = 1'b0;
					pins_next.low_byte_enable_n = 1'b1;
					pins_next.high_byte_enable_n = 1'b1;
					tload = 1'b1;
					tcount = CNT_W'(CP_CYC);
					state_next = ST_IDLE;
				end
			end
			ST_PD_SETUP: begin
				if (tdone) begin
					pins_next.power_down_enable = 1'b0;
					tload = 1'b1;
					tcount = CNT_W'(PD_HOLD_CYC);
					state_next = ST_PD_HOLD;
				end
			end
			ST_PD_HOLD: begin
				if (tdone) begin
					state_next = ST_PD_OFF;
				end
			end
			ST_PD_OFF: begin
				if (req_valid && req.cmd != PSAC_CMD_SLEEP) begin
					pins_next.power_down_enable = 1'b1;
					tload = 1'b1;
					tcount = req_reg.partial ? CNT_W'(PWAKE_CYC) : CNT_W'(WAKE_CYC);
					state_next = ST_WAKE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// state and pin registers
	// ---------------------------------------------------------------
	// power-up hold is loaded once, on the first clock after reset
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pu_armed_reg <= 1'b0;
		end else begin
			pu_armed_reg <= 1'b1;
		end
	end

	// every timed phase is a clock count; ST_IDLE and ST_PD_OFF wait for a request
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= ST_PU_LOW;
		end else begin
			state_reg <= state_next;
		end
	end

	// pins reset to a deselected, powered-down, hi-z state
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pins_reg <= '{primary_chip_enable_n: 1'b1, power_down_enable: 1'b0,
				output_enable_n: 1'b1, write_enable_n: 1'b1, low_byte_enable_n: 1'b1,
				high_byte_enable_n: 1'b1, addr: '0, dq_out: '0, dq_oe: 1'b0};
		end else begin
			pins_reg <= pins_next;
		end
	end

	// ---------------------------------------------------------------
	// request capture and bookkeeping
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			req_reg <= '0;
			last_was_write_reg <= 1'b0;
		end else if (take) begin
			req_reg <= req;
			last_was_write_reg <= (req.cmd == PSAC_CMD_WRITE);
		end
	end

	// page beat counter; restarts at each accepted request
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			beat_reg <= '0;
		end else if (take) begin
			beat_reg <= '0;
		end else if (rvalid_next) begin
			beat_reg <= beat_reg + 3'd1;
		end
	end

	// read data captured from the synchronised bus
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rdata_reg <= '0;
			rvalid_reg <= 1'b0;
		end else begin
			rvalid_reg <= rvalid_next;
			if (rvalid_next) begin
				rdata_reg <= dq_s2_reg;
			end
		end
	end

	// ready level shows the memory is awake and idle
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ready_reg <= 1'b0;
		end else begin
			ready_reg <= (state_next == ST_IDLE);
		end
	end

	assign pins = pins_reg;
	assign rdata = rdata_reg;
	assign rdata_valid = rvalid_reg;
	assign ready_for_use = ready_reg;
endmodule // psac_host

/* File: logic/psac_pkg.sv */
// package: pin bundle, request types and timing counts for the pseudo-static ram host
package psac_pkg;

	localparam int CLK_PERIOD_NS = 20;
	localparam int ADDR_W = 22;
	localparam int DATA_W = 16;

	// timing figures as printed, in their own unit
	localparam int READ_CYCLE_TIME_NS = 70;        // covers 16M and 32M/64M minima
	localparam int PAGE_ACCESS_TIME_NS = 20;
	localparam int PAGE_READ_CYCLE_TIME_NS = 20;
	localparam int WRITE_PULSE_NS = 45;
	localparam int WRITE_CYCLE_TIME_NS = 70;
	localparam int WRITE_RECOVERY_TIME_NS = 0;
	localparam int READ_SUPPRESS_WINDOW_NS = 5;
	localparam int WRITE_TO_READ_GAP_NS = 25;
	localparam int POWER_DOWN_SETUP_NS = 10;
	localparam int POWER_DOWN_HOLD_NS = 80;
	localparam int WAKE_HOLD_TIME_US = 300;
	localparam int PARTIAL_WAKE_HOLD_US = 1;
	localparam int POWERUP_LOW_HOLD_US = 50;
	localparam int STANDBY_WRITE_HOLD_NS = 10;
	localparam int STANDBY_OE_HOLD_NS = 10;
	localparam int CHIP_HIGH_PULSE_NS = 12;
	localparam int CYCLE_MAX_NS = 1000;
	localparam int PAGE_CLOSE_MAX_US = 4;
	localparam int BYTE_PULSE_OVERLAP_NS = 30;

	// minimum intervals round up, maximum intervals round down
	function automatic int cyc_min(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction
	function automatic int cyc_max(input int ns);
		int c;
		c = ns / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int READ_CYC = cyc_min(READ_CYCLE_TIME_NS);
	localparam int PAGE_CYC = cyc_min(PAGE_READ_CYCLE_TIME_NS);
	localparam int PAGE_ACC_CYC = cyc_min(PAGE_ACCESS_TIME_NS);
	localparam int WPULSE_CYC = cyc_min(WRITE_PULSE_NS);
	localparam int WCYCLE_CYC = cyc_min(WRITE_CYCLE_TIME_NS);
	localparam int WREC_CYC = cyc_min(WRITE_CYCLE_TIME_NS - WRITE_PULSE_NS
		+ WRITE_RECOVERY_TIME_NS);
	localparam int GAP_CYC = cyc_min(WRITE_TO_READ_GAP_NS);
	localparam int PD_SETUP_CYC = cyc_min(POWER_DOWN_SETUP_NS);
	localparam int PD_HOLD_CYC = cyc_min(POWER_DOWN_HOLD_NS);
	localparam int HOLD_CYC = cyc_min(STANDBY_WRITE_HOLD_NS);
	localparam int CP_CYC = cyc_min(CHIP_HIGH_PULSE_NS);
	localparam int CYCLE_MAX_CYC = cyc_max(CYCLE_MAX_NS);
	localparam int PAGE_CLOSE_CYC = cyc_max(PAGE_CLOSE_MAX_US * 1000);
	localparam int WAKE_CYC_DEF = cyc_min(WAKE_HOLD_TIME_US * 1000);
	localparam int PWAKE_CYC = cyc_min(PARTIAL_WAKE_HOLD_US * 1000);
	localparam int PU_LOW_CYC_DEF = cyc_min(POWERUP_LOW_HOLD_US * 1000);
	localparam int CNT_W = 16;
	localparam int PAGE_BEATS = 8;

	typedef enum logic [1:0] {
		PSAC_CMD_READ,
		PSAC_CMD_PAGE_READ,
		PSAC_CMD_WRITE,
		PSAC_CMD_SLEEP
	} psac_cmd_type;

	typedef struct packed {
		psac_cmd_type cmd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [1:0] byte_en;
		logic partial;
	} psac_req_type;

	typedef struct packed {
		logic primary_chip_enable_n;
		logic power_down_enable;
		logic output_enable_n;
		logic write_enable_n;
		logic low_byte_enable_n;
		logic high_byte_enable_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dq_out;
		logic dq_oe;
	} psac_pins_type;

endpackage

/* File: logic/psac_timer.sv */
// down counter that times every pin interval of the host
module psac_timer (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic load,
	input wire logic [psac_pkg::CNT_W-1:0] count,
	output logic done
);
	import psac_pkg::*;

	logic [CNT_W-1:0] cnt_reg;

	// ---------------------------------------------------------------
	// counter
	// ---------------------------------------------------------------
	// reload wins over the count so back-to-back phases lose no cycle
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			cnt_reg <= '0;
		end else if (load) begin
			cnt_reg <= count;
		end else if (cnt_reg != '0) begin
			cnt_reg <= cnt_reg - 1'b1;
		end
	end

	// done ignores load, so the ready path has no loop back through the load
	assign done = (cnt_reg == '0);
endmodule // psac_timer

/* File: test/psac_host_props.sv */
// checker of pin timing at the pseudo-static ram host ports
module psac_host_props #(
	parameter int WAKE_CYC = 20,
	parameter int PU_LOW_CYC = 10
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic req_valid,
	input psac_pkg::psac_req_type req,
	input wire logic req_ready,
	input wire logic [psac_pkg::DATA_W-1:0] rdata,
	input wire logic rdata_valid,
	input wire logic ready_for_use,
	input psac_pkg::psac_pins_type pins,
	input wire logic [psac_pkg::DATA_W-1:0] dq_in
);
	import psac_pkg::*;
	// a partial wake may be shorter than a sleep wake, so take the lesser
	localparam int WAKE_LIM = (WAKE_CYC < PWAKE_CYC) ? WAKE_CYC : PWAKE_CYC;
	wire logic ce_n = pins.primary_chip_enable_n;
	wire logic we_n = pins.write_enable_n;
	wire logic oe_n = pins.output_enable_n;
	wire logic pde = pins.power_down_enable;
	wire logic no_lane = pins.low_byte_enable_n & pins.high_byte_enable_n;
	int lo_cnt;
	int wake_cnt;
	int up_cnt;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);

	// ----------------------------------------
	// helper counters
	// ----------------------------------------
	// length of the current chip enable low run
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) lo_cnt <= 0;
		else lo_cnt <= ce_n ? 0 : lo_cnt + 1;
	end
	// cycles since power-down enable went high, saturating
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) wake_cnt <= 0;
		else if (!pde) wake_cnt <= 0;
		else if (wake_cnt < 65535) wake_cnt <= wake_cnt + 1;
	end
	// cycles since reset release, saturating
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) up_cnt <= 0;
		else if (up_cnt < 65535) up_cnt <= up_cnt + 1;
	end

	sequence s_we_low;
		!we_n [*3];
	endsequence
	sequence s_row_still;
		$stable(pins.addr[ADDR_W-1:3]) [*3];
	endsequence
	sequence s_oe_quiet;
		oe_n [*2];
	endsequence

	// ----------------------------------------
	// pin relations
	// ----------------------------------------
	// write only with read gate shut
	a_we_in_chip: assert property (!we_n |-> !ce_n && oe_n && !no_lane)
		else $error("write enable low outside a clean write");
	a_we_pulse: assert property ($fell(we_n) |-> s_we_low)
		else $error("write pulse too short");
	a_pulse_end: assert property ($rose(we_n) |-> !ce_n && pins.dq_oe && $stable(pins.dq_out))
		else $error("write pulse not ended by write enable with data held");
	a_ce_we_hold: assert property ($rose(ce_n) |-> we_n && $past(we_n))
		else $error("write enable not settled at chip enable rise");
	a_ce_oe_hold: assert property ($rose(ce_n) |-> $stable(oe_n))
		else $error("output enable moved with chip enable rise");
	a_addr_hold: assert property ($fell(ce_n) |=> s_row_still)
		else $error("address changed within the read cycle");
	a_cycle_max: assert property (lo_cnt < CYCLE_MAX_CYC)
		else $error("chip enable low too long");
	a_pd_hold: assert property ($fell(pde) |-> !pde [*4])
		else $error("power-down enable low too short");
	a_wake_hold: assert property ($fell(ce_n) |-> wake_cnt >= WAKE_LIM)
		else $error("access too soon after wake");
	a_powerup_low: assert property ($rose(pde) |-> up_cnt >= PU_LOW_CYC)
		else $error("power-down enable rose too soon after reset");
	a_read_lane: assert property (!ce_n && !oe_n |-> !no_lane)
		else $error("read with no byte lane");
	a_gap_read: assert property ($rose(we_n) |-> s_oe_quiet)
		else $error("output enable fell too soon after write");
endmodule // psac_host_props

bind psac_host psac_host_props #(.WAKE_CYC(WAKE_CYC), .PU_LOW_CYC(PU_LOW_CYC)) u_props (
	.core_clk(core_clk), .resetn(resetn), .req_valid(req_valid), .req(req),
	.req_ready(req_ready), .rdata(rdata), .rdata_valid(rdata_valid),
	.ready_for_use(ready_for_use), .pins(pins), .dq_in(dq_in));

/* File: test/psac_mem_model.sv */
// behavioural pseudo-static ram answering the host pins
module psac_mem_model (
	input psac_pkg::psac_pins_type pins,
	output logic [psac_pkg::DATA_W-1:0] dq_in
);
	timeunit 1ns;
	timeprecision 1ps;
	import psac_pkg::*;
	// only eight address bits kept, so addresses above 255 (such as the page test's 0x108) alias onto the low 256 words
	logic [DATA_W-1:0] mem [0:255];
	logic [DATA_W-1:0] last = 16'h0000;
	psac_pins_type p;
	initial dq_in = 16'h0000;

	always @(pins) begin
		if (!p.primary_chip_enable_n && !p.write_enable_n && !(pins.primary_chip_enable_n === 1'b0
			&& pins.write_enable_n === 1'b0)) begin
			if (!p.low_byte_enable_n) mem[p.addr[7:0]][7:0] = p.dq_out[7:0];
			if (!p.high_byte_enable_n) mem[p.addr[7:0]][15:8] = p.dq_out[15:8];
		end
		// sleep loses the contents, as the real array does
		if (pins.power_down_enable === 1'b0) foreach (mem[i]) mem[i] = 'x;
		p = pins;
	end
	always @(pins) begin
		if (!pins.primary_chip_enable_n && !pins.output_enable_n && pins.write_enable_n) begin
			last = mem[pins.addr[7:0]];
			dq_in <= #10 last;
		end else begin
			dq_in <= #10 ~last; // released bus shows no stale word
		end
	end
endmodule // psac_mem_model

/* File: test/testbench.sv */
// self-checking bench for the pseudo-static ram host
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import psac_pkg::*;
	localparam int WAKE_SIM = 20;
	localparam int PU_SIM = 10;
	logic core_clk;
	logic resetn;
	logic req_valid;
	psac_req_type req;
	logic req_ready;
	logic [DATA_W-1:0] rdata;
	logic rdata_valid;
	logic ready_for_use;
	psac_pins_type pins;
	logic [DATA_W-1:0] dq_in;
	logic [DATA_W-1:0] shadow [0:255];
	int error_cnt;
	int samples_checked;

	psac_host #(.WAKE_CYC(WAKE_SIM), .PU_LOW_CYC(PU_SIM)) u_dut (
		.core_clk(core_clk), .resetn(resetn), .req_valid(req_valid), .req(req),
		.req_ready(req_ready), .rdata(rdata), .rdata_valid(rdata_valid),
		.ready_for_use(ready_for_use), .pins(pins), .dq_in(dq_in));
	psac_mem_model u_mem (.pins(pins), .dq_in(dq_in));

	// 50 MHz clock
	always #10 core_clk = ~core_clk;

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic summarize();
		$display("mismatches %0d comparisons %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic bad(input string msg);
		$display("BAD %0t %s", $time, msg);
		error_cnt++;
	endtask
	task automatic chk_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		samples_checked++;
		if (got !== exp) bad($sformatf("read %h expected %h", got, exp));
	endtask
	task automatic chk_bit(input logic got, input logic exp, input string what);
		samples_checked++;
		if (got !== exp) bad(what);
	endtask
	// mid-cycle wait, so flags are settled; the bound ends the run on a hang
	task automatic wait_sig(input int sel, input logic val, output int n);
		logic s;
		for (n = 0; n < 4000; n++) begin
			@(negedge core_clk);
			case (sel)
				0: s = req_ready;
				1: s = rdata_valid;
				2: s = ready_for_use;
				default: s = pins.power_down_enable;
			endcase
			if (s === val) return;
		end
		bad("wait timed out");
		summarize();
	endtask
	// request held until the edge that takes it
	task automatic send(input psac_cmd_type c, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d, input logic [1:0] be);
		int n;
		@(posedge core_clk);
		req_valid <= 1'b1;
		req <= '{cmd: c, addr: a, wdata: d, byte_en: be, partial: 1'b0};
		wait_sig(0, 1'b1, n);
		@(posedge core_clk);
		req_valid <= 1'b0;
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
		input logic [1:0] be);
		send(PSAC_CMD_WRITE, a, d, be);
		if (be[0]) shadow[a[7:0]][7:0] = d[7:0];
		if (be[1]) shadow[a[7:0]][15:8] = d[15:8];
	endtask
	task automatic get_word(input logic [7:0] idx);
		int n;
		wait_sig(1, 1'b1, n);
		chk_word(rdata, shadow[idx]);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	// power-up holds before the first access
	task automatic t_powerup();
		int n;
		wait_sig(3, 1'b1, n);
		chk_bit(n >= PU_SIM, 1'b1, "power-down enable rose early");
		wait_sig(2, 1'b1, n);
		chk_bit(n >= WAKE_SIM, 1'b1, "usable before wake hold");
	endtask
	// full and low-lane writes back to back, then the high lane alone, each lane write read back
	task automatic t_lanes();
		wr(22'h00_0040, 16'ha1b2, 2'b11);
		wr(22'h00_0040, 16'hc3d4, 2'b01);
		send(PSAC_CMD_READ, 22'h00_0040, 16'h0000, 2'b11);
		get_word(8'h40);
		wr(22'h00_0040, 16'he5f6, 2'b10);
		send(PSAC_CMD_READ, 22'h00_0040, 16'h0000, 2'b11);
		get_word(8'h40);
	endtask
	// page read from mid-page wraps inside the page
	task automatic t_page();
		logic [7:0] idx;
		for (int i = 0; i < 8; i++) wr(22'h00_0108 + i, 16'h5a00 + 16'(i), 2'b11);
		send(PSAC_CMD_PAGE_READ, 22'h00_010d, 16'h0000, 2'b11);
		for (int i = 0; i < PAGE_BEATS; i++) begin
			idx = {5'h01, 3'(5 + i)};
			get_word(idx);
		end
	endtask
	// sleep, then a write wakes the memory and is served
	task automatic t_sleep();
		int n;
		send(PSAC_CMD_SLEEP, 22'h00_0000, 16'h0000, 2'b00);
		wait_sig(3, 1'b0, n);
		chk_bit(n <= PD_SETUP_CYC + 2, 1'b1, "sleep entered late");
		repeat (PD_HOLD_CYC) @(negedge core_clk);
		chk_bit(pins.power_down_enable, 1'b0, "sleep not held");
		wr(22'h00_0077, 16'h3c5a, 2'b11);
		chk_bit(pins.power_down_enable, 1'b1, "not awake after write");
		send(PSAC_CMD_READ, 22'h00_0077, 16'h0000, 2'b11);
		get_word(8'h77);
	endtask

	initial begin
		core_clk = 1'b0;
		resetn = 1'b0;
		req_valid = 1'b0;
		req = '0;
		error_cnt = 0;
		samples_checked = 0;
		repeat (10) @(posedge core_clk);
		resetn <= 1'b1;
		t_powerup();
		t_lanes();
		t_page();
		t_sleep();
		summarize();
	end
endmodule // testbench
